// ===== verilog/dior_pkg.sv
// constants and types of the four-line digital i/o function router
// assumes a 10 MHz pclk and software access over apb with 32-bit data
package dior_pkg;
   localparam int          DIOR_LINES          = 4;
   localparam int          DIOR_LANE_W         = 8;
   // register byte offsets
   localparam logic [7:0]  DIOR_OFS_MODE       = 8'h00;
   localparam logic [7:0]  DIOR_OFS_IN_FUNC    = 8'h04;
   localparam logic [7:0]  DIOR_OFS_OUT_SRC    = 8'h08;
   localparam logic [7:0]  DIOR_OFS_USER_FLAGS = 8'h0c;
   localparam logic [7:0]  DIOR_OFS_STATUS     = 8'h10;
   // reset values
   localparam logic [7:0]  DIOR_MODE_RST       = 8'h00;
   localparam logic [31:0] DIOR_IN_FUNC_RST    = 32'h0000_0000;
   localparam logic [31:0] DIOR_OUT_SRC_RST    = 32'h0000_0000;
   localparam logic [3:0]  DIOR_USER_RST       = 4'h0;
   // field layout: mode two bits per line, function and source one byte per line
   localparam int          DIOR_MODE_W         = 2;
   localparam int          DIOR_FN_LSB         = 0;
   localparam int          DIOR_IDX_LSB        = 4;
   localparam int          DIOR_ACT_BIT        = 6;
   localparam int          DIOR_GRP_LSB        = 5;
   localparam int          DIOR_STAT_OUT_LSB   = 4;
   localparam int          DIOR_STAT_PSET_LSB  = 8;
   localparam int          DIOR_STAT_RANGE_BIT = 16;
   // refresh tick: longest allowed period, rounded down to whole cycles
   localparam int          DIOR_TICK_PERIOD_NS = 100000;
   localparam int          DIOR_CLK_PERIOD_NS  = 100;
   localparam int          DIOR_TICK_CYCLES    = DIOR_TICK_PERIOD_NS / DIOR_CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      DIOR_MODE_IN,
      DIOR_MODE_OUT,
      DIOR_MODE_PSET
   } dior_mode_t;

   typedef enum logic [2:0] {
      DIOR_FN_NONE,
      DIOR_FN_RANGE,
      DIOR_FN_CHAN,
      DIOR_FN_PEAK,
      DIOR_FN_HELD
   } dior_fn_t;

   typedef enum logic [2:0] {
      DIOR_GRP_CONST,
      DIOR_GRP_DIO,
      DIOR_GRP_FIELDBUS,
      DIOR_GRP_USER,
      DIOR_GRP_VALID,
      DIOR_GRP_LIMIT,
      DIOR_GRP_STATUS
   } dior_grp_t;

   typedef struct packed {
      logic [3:0] zero_set;
      logic [3:0] zero_clear;
      logic [3:0] hw_reset;
      logic [3:0] sw_reset;
      logic [3:0] peak_reset;
      logic [3:0] held_reset;
   } dior_act_t;
endpackage

// ===== verilog/dior_tick.sv
// periodic tick generator for the i/o refresh
// assumes one free-running clock; tick is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
module dior_tick #(
   parameter int CYCLES = dior_pkg::DIOR_TICK_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);
   localparam int CW = $clog2(CYCLES);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          tick_reg;
   logic          tick_next;

   always_comb begin
      tick_next = 1'b0;
      if (cnt_reg == CW'(CYCLES - 1)) begin
         cnt_next  = '0;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule

// ===== verilog/dior_router.sv
// four-line digital i/o function router with apb register access
// assumes field inputs already synchronous to pclk; pad logic resolves dio_oe
//
// Summary of operation
// - four lines, each set to exactly one of input, output or parameter-set mode.
// - parameter-set lines together form the active parameter set number.
// - a range input switches the piezo inputs between small and large range by its level.
// - a channel input sets or clears zero on strain channels, or hard or soft resets piezo ones.
// - an input can reset one selected peak statistic or one selected held statistic.
// - an output line can show any selected device status or error object.
// - an output can also show dio, fieldbus, user, valid or limit flags, or constant 1 or 0.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
module dior_router #(
   parameter int TICK_CYCLES = dior_pkg::DIOR_TICK_CYCLES,
   parameter int STATUS_W    = 32
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [3:0]        dio_in,
   output logic [3:0]             dio_out,
   output logic [3:0]             dio_oe,
   input  wire logic [3:0]        ch_is_piezo,
   input  wire logic [3:0]        fieldbus_flags,
   input  wire logic [3:0]        chan_valid,
   input  wire logic [7:0]        limit_sw,
   input  wire logic [STATUS_W-1:0] dev_status,
   output logic [3:0]             pset_active,
   output logic                   piezo_range_small,
   output dior_pkg::dior_act_t    act
);
   logic        tick;
   logic [7:0]  mode_reg,   mode_next;
   logic [31:0] fn_reg,     fn_next;
   logic [31:0] src_reg,    src_next;
   logic [3:0]  user_reg,   user_next;
   logic [3:0]  smp_reg,    smp_next;
   logic [3:0]  out_reg,    out_next;
   logic [3:0]  oe_reg,     oe_next;
   logic [3:0]  pset_reg,   pset_next;
   logic        range_reg,  range_next;
   logic [31:0] rdata_reg,  rdata_next;
   logic        ready_reg,  ready_next;
   logic        err_reg,    err_next;
   logic [3:0]  dio_level;
   dior_pkg::dior_act_t act_reg, act_next;

   dior_tick #(
      .CYCLES  (TICK_CYCLES)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   function automatic dior_pkg::dior_mode_t line_mode(input logic [7:0] m, input int i);
      logic [1:0] f;
      f = m[i*dior_pkg::DIOR_MODE_W +: dior_pkg::DIOR_MODE_W];
      // reserved code falls back to input so a line never drives by accident
      if (f == 2'h1) begin
         line_mode = dior_pkg::DIOR_MODE_OUT;
      end else if (f == 2'h2) begin
         line_mode = dior_pkg::DIOR_MODE_PSET;
      end else begin
         line_mode = dior_pkg::DIOR_MODE_IN;
      end
   endfunction

   function automatic logic sel_source(input logic [7:0] src, input logic [3:0] dio,
                                       input logic [3:0] usr);
      logic [4:0] idx;
      idx = src[4:0];
      case (src[7:dior_pkg::DIOR_GRP_LSB])
         dior_pkg::DIOR_GRP_CONST:    sel_source = idx[0];
         dior_pkg::DIOR_GRP_DIO:      sel_source = dio[idx[1:0]];
         dior_pkg::DIOR_GRP_FIELDBUS: sel_source = fieldbus_flags[idx[1:0]];
         dior_pkg::DIOR_GRP_USER:     sel_source = usr[idx[1:0]];
         dior_pkg::DIOR_GRP_VALID:    sel_source = chan_valid[idx[1:0]];
         dior_pkg::DIOR_GRP_LIMIT:    sel_source = limit_sw[idx[2:0]];
         dior_pkg::DIOR_GRP_STATUS: begin
            sel_source = (int'(idx) < STATUS_W) ? dev_status[idx] : 1'b0;
         end
         default:                     sel_source = 1'b0;
      endcase
   endfunction

   // dio flags show the line as it stands: driven level or sampled input
   assign dio_level = (oe_reg & out_reg) | (~oe_reg & smp_reg);

   // field side: everything is set only on the tick; act pulses clear again the cycle after
   always_comb begin
      int         k;
      logic [7:0] lane;
      logic [1:0] idx;
      logic       rise;
      k          = 0;
      lane       = '0;
      idx        = '0;
      rise       = 1'b0;
      smp_next   = smp_reg;
      out_next   = out_reg;
      oe_next    = oe_reg;
      pset_next  = pset_reg;
      range_next = range_reg;
      act_next   = '0;
      if (tick) begin
         smp_next  = dio_in;
         pset_next = '0;
         for (int i = 0; i < dior_pkg::DIOR_LINES; i++) begin
            lane = fn_reg[i*dior_pkg::DIOR_LANE_W +: dior_pkg::DIOR_LANE_W];
            idx  = lane[dior_pkg::DIOR_IDX_LSB +: 2];
            rise = dio_in[i] & ~smp_reg[i];
            case (line_mode(mode_reg, i))
               dior_pkg::DIOR_MODE_OUT: begin
                  oe_next[i]  = 1'b1;
                  out_next[i] = sel_source(src_reg[i*dior_pkg::DIOR_LANE_W +:
                                           dior_pkg::DIOR_LANE_W],
                                           dio_level, user_reg);
               end
               dior_pkg::DIOR_MODE_PSET: begin
                  oe_next[i]  = 1'b0;
                  out_next[i] = 1'b0;
                  pset_next[k[1:0]] = dio_in[i];
                  k = k + 1;
               end
               default: begin
                  oe_next[i]  = 1'b0;
                  out_next[i] = 1'b0;
                  case (lane[2:0])
                     dior_pkg::DIOR_FN_RANGE: begin
                        range_next = ~dio_in[i];
                     end
                     dior_pkg::DIOR_FN_CHAN: begin
                        // actions fire once per rising input edge
                        if (rise) begin
                           if (!ch_is_piezo[idx] && !lane[dior_pkg::DIOR_ACT_BIT]) begin
                              act_next.zero_set[idx] = 1'b1;
                           end else if (!ch_is_piezo[idx]) begin
                              act_next.zero_clear[idx] = 1'b1;
                           end else if (!lane[dior_pkg::DIOR_ACT_BIT]) begin
                              act_next.hw_reset[idx] = 1'b1;
                           end else begin
                              act_next.sw_reset[idx] = 1'b1;
                           end
                        end
                     end
                     dior_pkg::DIOR_FN_PEAK: begin
                        act_next.peak_reset[idx] = act_next.peak_reset[idx] | rise;
                     end
                     dior_pkg::DIOR_FN_HELD: begin
                        act_next.held_reset[idx] = act_next.held_reset[idx] | rise;
                     end
                     default: begin
                     end
                  endcase
               end
            endcase
         end
      end
   end

   // apb slave: answer one cycle into the access phase, commit at the completing edge
   always_comb begin
      mode_next  = mode_reg;
      fn_next    = fn_reg;
      src_next   = src_reg;
      user_next  = user_reg;
      rdata_next = rdata_reg;
      ready_next = 1'b0;
      err_next   = 1'b0;
      if (psel && penable && !ready_reg) begin
         ready_next = 1'b1;
         rdata_next = '0;
         case (paddr)
            dior_pkg::DIOR_OFS_MODE:       rdata_next[7:0] = mode_reg;
            dior_pkg::DIOR_OFS_IN_FUNC:    rdata_next      = fn_reg;
            dior_pkg::DIOR_OFS_OUT_SRC:    rdata_next      = src_reg;
            dior_pkg::DIOR_OFS_USER_FLAGS: rdata_next[3:0] = user_reg;
            dior_pkg::DIOR_OFS_STATUS: begin
               rdata_next[3:0] = smp_reg;
               rdata_next[dior_pkg::DIOR_STAT_OUT_LSB +: 4]  = out_reg;
               rdata_next[dior_pkg::DIOR_STAT_PSET_LSB +: 4] = pset_reg;
               rdata_next[dior_pkg::DIOR_STAT_RANGE_BIT]     = range_reg;
            end
            default:                       err_next = 1'b1;
         endcase
      end else if (psel && penable && ready_reg) begin
         if (pwrite && !err_reg) begin
            case (paddr)
               dior_pkg::DIOR_OFS_MODE:       mode_next = pwdata[7:0];
               dior_pkg::DIOR_OFS_IN_FUNC:    fn_next   = pwdata;
               dior_pkg::DIOR_OFS_OUT_SRC:    src_next  = pwdata;
               dior_pkg::DIOR_OFS_USER_FLAGS: user_next = pwdata[3:0];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg  <= dior_pkg::DIOR_MODE_RST;
         fn_reg    <= dior_pkg::DIOR_IN_FUNC_RST;
         src_reg   <= dior_pkg::DIOR_OUT_SRC_RST;
         user_reg  <= dior_pkg::DIOR_USER_RST;
         smp_reg   <= '0;
         out_reg   <= '0;
         oe_reg    <= '0;
         pset_reg  <= '0;
         range_reg <= 1'b0;
         act_reg   <= '0;
         rdata_reg <= '0;
         ready_reg <= 1'b0;
         err_reg   <= 1'b0;
      end else begin
         mode_reg  <= mode_next;
         fn_reg    <= fn_next;
         src_reg   <= src_next;
         user_reg  <= user_next;
         smp_reg   <= smp_next;
         out_reg   <= out_next;
         oe_reg    <= oe_next;
         pset_reg  <= pset_next;
         range_reg <= range_next;
         act_reg   <= act_next;
         rdata_reg <= rdata_next;
         ready_reg <= ready_next;
         err_reg   <= err_next;
      end
   end

   assign prdata            = rdata_reg;
   assign pready            = ready_reg;
   assign pslverr           = err_reg;
   assign dio_out           = out_reg;
   assign dio_oe            = oe_reg;
   assign pset_active       = pset_reg;
   assign piezo_range_small = range_reg;
   assign act               = act_reg;
endmodule

// ===== dv/dior_router_props.sv
// checker for the i/o router: tick spacing of field outputs, apb answer shape
// bound to every dior_router instance; sees only its ports
`timescale 1ns/100ps
module dior_router_props #(
   parameter int TICK_CYCLES = dior_pkg::DIOR_TICK_CYCLES
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic [3:0]       dio_out,
   input wire logic [3:0]       dio_oe,
   input wire logic [3:0]       pset_active,
   input wire logic             piezo_range_small,
   input wire dior_pkg::dior_act_t act
);
   int lvl_gap;
   int act_gap;
   // cycles since the last level change and the last action pulse, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_gap <= TICK_CYCLES;
         act_gap <= TICK_CYCLES;
      end else begin
         if ($changed({dio_out, dio_oe, pset_active, piezo_range_small})) lvl_gap <= 1;
         else if (lvl_gap < TICK_CYCLES) lvl_gap <= lvl_gap + 1;
         if (act != 24'h0) act_gap <= 1;
         else if (act_gap < TICK_CYCLES) act_gap <= act_gap + 1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   out_oe_a: assert property ((dio_out & ~dio_oe) == 4'h0) else $error("drive off line");
   oe_tick_a: assert property ($changed(dio_oe) |-> lvl_gap >= TICK_CYCLES) else $error("oe");
   pset_tick_a: assert property ($changed(pset_active) |-> lvl_gap >= TICK_CYCLES) else $error("pset");
   pset_width_a: assert property ((pset_active >> (4 - $countones(dio_oe))) == 4'h0)
      else $error("pset bit without line");
   range_tick_a: assert property ($changed(piezo_range_small) |-> lvl_gap >= TICK_CYCLES)
      else $error("range off tick");
   act_pulse_a: assert property (act != 24'h0 |=> act == 24'h0) else $error("act long");
   act_tick_a: assert property (act != 24'h0 |-> act_gap >= TICK_CYCLES) else $error("act");
   act_input_a: assert property (act != 24'h0 |-> dio_oe != 4'hf) else $error("act no input");
   out_tick_a: assert property ($changed(dio_out) |-> lvl_gap >= TICK_CYCLES) else $error("out");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready long");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
endmodule
bind dior_router dior_router_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.pclk, .presetn, .pready,
   .pslverr, .dio_out, .dio_oe, .pset_active, .piezo_range_small, .act);

// ===== dv/dior_field_model.sv
// field wiring model: switches on input lines, read-back of driven lines
// assumes the bench sets the switch levels; output lines loop back as driven
`timescale 1ns/100ps
module dior_field_model (
   input wire logic [3:0] dio_out,
   input wire logic [3:0] dio_oe,
   input wire logic [3:0] lvl,
   output logic [3:0]     dio_in
);
   assign dio_in = (dio_oe & dio_out) | (~dio_oe & lvl);
endmodule

// ===== dv/dior_router_tb_top.sv
// self-checking bench for the digital i/o router
// assumes a short tick parameter so each field update lands within a few dozen cycles
`timescale 1ns/100ps
module dior_router_tb_top;
   localparam int TICK = 8;
   logic                pclk = 1'b0;
   logic                presetn = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [7:0]          paddr = 8'h00;
   logic [31:0]         pwdata = 32'h0;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [3:0]          dio_in;
   logic [3:0]          dio_out;
   logic [3:0]          dio_oe;
   logic [3:0]          ch_is_piezo = 4'h0;
   logic [3:0]          lvl = 4'h0;
   logic [3:0]          pset_active;
   logic                piezo_range_small;
   dior_pkg::dior_act_t act;
   logic [31:0]         rd;
   logic                err;
   int                  fails = 0;
   int                  num_checks = 0;
   always #50 pclk = ~pclk;
   dior_router #(.TICK_CYCLES(TICK)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .dio_in, .dio_out, .dio_oe, .ch_is_piezo,
      .fieldbus_flags(4'ha), .chan_valid(4'h5), .limit_sw(8'h80), .dev_status(32'h8000_0000),
      .pset_active, .piezo_range_small, .act);
   dior_field_model field (.dio_out, .dio_oe, .lvl, .dio_in);
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic wt();
      repeat (2 * TICK + 4) @(posedge pclk);
   endtask
   task automatic s_reset();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", rd, 32'h0);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped read", {31'h0, err}, 32'h1);
      apb(1'b1, 8'h24, 32'h5);
      chk("unmapped write", {31'h0, err}, 32'h1);
   endtask
   task automatic s_pset();
      // line 3 uses the reserved code, which must behave as input
      apb(1'b1, 8'h00, 32'hda);
      lvl <= 4'b0001;
      wt();
      chk("oe", {28'h0, dio_oe}, 32'h4);
      chk("pset", {28'h0, pset_active}, 32'h1);
      lvl <= 4'b1011;
      wt();
      chk("pset", {28'h0, pset_active}, 32'h3);
      chk("oe reserved", {28'h0, dio_oe}, 32'h4);
      apb(1'b0, 8'h00, 32'h0);
      chk("mode readback", rd, 32'h0000_00da);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      chk("status write", {31'h0, err}, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("status", rd, 32'h0000_030b);
   endtask
   task automatic s_out();
      // levels alternate except that entries 2 and 5 repeat the 1 before them, so a stuck output cannot pass every entry
      logic [7:0] src[13] = '{8'h00, 8'h01, 8'h23, 8'h40, 8'h41, 8'h62, 8'h81, 8'h80,
                              8'ha0, 8'ha7, 8'hc0, 8'hdf, 8'hff};
      logic       exp[13] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
                              1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      apb(1'b1, 8'h0c, 32'h4);
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, 8'h08, {8'h00, src[i], 16'h0});
         wt();
         chk("out source", {31'h0, dio_out[2]}, {31'h0, exp[i]});
      end
   endtask
   task automatic wait_act(input logic [23:0] exp);
      int n;
      for (n = 0; n < 3 * TICK && act === 24'h0; n++) @(posedge pclk);
      chk("act", {8'h0, act}, {8'h0, exp});
      if (n >= 3 * TICK) stop_test();
   endtask
   task automatic s_act();
      apb(1'b1, 8'h00, 32'h0);
      lvl <= 4'h0;
      for (int j = 0; j < 4; j++) begin
         ch_is_piezo <= {1'b0, j[1], 2'b00};
         // line 1 acts on channel 2; bit 6 picks the action, piezo flag picks the kind
         apb(1'b1, 8'h04, {8'h14, 8'h33, 1'b0, j[0], 6'h22, 8'h01});
         wt();
         lvl <= 4'b0010;
         wait_act(24'h1 << (22 - 4 * j));
         lvl <= 4'h0;
      end
      wt();
      chk("range small", {31'h0, piezo_range_small}, 32'h1);
      lvl <= 4'b1101;
      wait_act(24'h000082);
      wt();
      chk("range large", {31'h0, piezo_range_small}, 32'h0);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_pset();
      s_out();
      s_act();
      stop_test();
   end
endmodule
